/* rtl/epv_port.sv */
// program and verify port of the one-time-programmable code memory
//
// Notes on behaviour
// [R1] mode code is ten bits, least significant first, one per oscillator clock
// [R2] bits sampled while oscillator is high; programmer changes them while low
// [R3] programmer holds reset pin high two machine cycles before the code
// [R4] strobe and high-voltage pins idle high; programmer drives them high first
// [R5] programmer keeps reset pin low for the whole session
// [R6] upper address bits latched when byte select falls after 13 clocks high
// [R7] programmer keeps upper bits on port 3 two clocks after select falls
// [R8] low address byte taken as stable 13 clocks after it is applied
// [R9] byte select pulsed again only when the upper bits change
// [R10] programming voltage turns port 1 into a data input
// [R11] twenty-five strobe pulses program the byte; strobe left high after
// [R12] voltage back to normal gives verify, data on port 1 after 48 clocks
// [R13] user verify data is stored byte xnor key entry from low four bits
// [R14] erased key entries pass the stored byte unchanged
// [R15] security bit 1 stops user and key programming and key verify
// [R16] security bit 2 stops user and key verify; bit levels still readable
// [R17] programming a security bit needs no address and no data
// [R18] bit verify shows bit 1 on port bit 7 and bit 2 on bit 6
// [R19] code 296H selects user memory, 292H the key table
// [R20] codes 29AH and 298H with programming voltage set bits 1 and 2
// [R21] code 29AH at normal levels selects security bit verify
// [R22] unknown mode code leaves the device out of session, arrays untouched
// [R23] programmer checks verify data; pulse count is a parameter
`timescale 1ns/1ps
`default_nettype none
module epv_port
  import epv_pkg::*;
#(
  parameter int MEM_DEPTH = 2048,
  parameter int PULSE_COUNT = 25
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // serial mode entry
  input wire logic oscillator_input,
  input wire logic reset_pin,
  // address port
  input wire logic address_byte_select,
  input wire logic [7:0] port3_in,
  // strobe and programming voltage
  input wire logic program_strobe_n,
  input wire logic vpp_applied,
  // data port and session flag
  input wire logic [7:0] port1_in,
  output logic [7:0] port1_out,
  output logic port1_oe,
  output logic session_active
);

  localparam int PW = 6;
  localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_COUNT);

  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_q;
    logic rpin_s1;
    logic rpin_s2;
    logic address_byte_select_s1;
    logic address_byte_select_s2;
    logic address_byte_select_q;
    logic strb_s1;
    logic strb_s2;
    logic strb_q;
    logic vpp_s1;
    logic vpp_s2;
    logic [7:0] p3_s1;
    logic [7:0] p3_s2;
    logic [7:0] p1_s1;
    logic [7:0] p1_s2;
    epv_state_e fsm;
    epv_mode_e mode;
    logic [CODE_BITS-1:0] code;
    logic [BITCNT_W-1:0] bitcnt;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] address_byte_select_cnt;
    logic [HI_BITS-1:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] p3_last;
    logic [CNT_W-1:0] lo_cnt;
    logic [CNT_W-1:0] vcnt;
    logic data_valid;
    logic [PW-1:0] pulses;
    logic prog_done;
    logic sec1;
    logic sec2;
    logic [KEY_DEPTH-1:0][7:0] key;
    logic [MEM_DEPTH-1:0][7:0] mem;
    logic [7:0] p1_out;
    logic p1_oe;
    logic in_sess;
  } epv_state_s;

  epv_state_s st;
  epv_state_s next_st;
  logic rst_m;
  logic rst_n;
  logic osc_rise;
  logic address_byte_select_fall;
  logic strb_rise;
  logic in_session;
  logic prog_on;
  logic verify_on;
  logic [ADDR_BITS-1:0] addr;
  logic [KEY_BITS-1:0] key_idx;
  logic [7:0] mem_byte;
  logic [7:0] key_byte;
  logic [7:0] vdata;
  logic [CODE_BITS-1:0] shifted;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // edges seen only on second-stage copies
  assign osc_rise = st.osc_s2 & ~st.osc_q;
  assign address_byte_select_fall = ~st.address_byte_select_s2 & st.address_byte_select_q;
  assign strb_rise = st.strb_s2 & ~st.strb_q;
  assign in_session = (st.fsm == S_SESSION);
  assign prog_on = in_session & st.vpp_s2;
  assign verify_on = in_session & ~st.vpp_s2 & st.strb_s2; // [R4]
  assign addr = {st.addr_hi, st.addr_lo};
  assign key_idx = st.addr_lo[KEY_BITS-1:0];
  assign mem_byte = st.mem[addr];
  assign key_byte = st.key[key_idx];
  assign shifted = {st.rpin_s2, st.code[CODE_BITS-1:1]}; // [R1]

  // verify data per target
  always_comb begin
    vdata = BLOCKED_BYTE;
    case (st.mode)
      M_USER: begin
        if (!st.sec2) vdata = ~(mem_byte ^ key_byte); // [R13] [R14]
      end
      M_KEY: begin
        if (!st.sec1 && !st.sec2) vdata = key_byte; // [R15] [R16]
      end
      M_SEC1: begin
        vdata[SEC1_BIT] = st.sec1; // [R18] [R21]
        vdata[SEC2_BIT] = st.sec2;
      end
      default: vdata = BLOCKED_BYTE;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.osc_s1 = oscillator_input;
    next_st.osc_s2 = st.osc_s1;
    next_st.osc_q = st.osc_s2;
    next_st.rpin_s1 = reset_pin;
    next_st.rpin_s2 = st.rpin_s1;
    next_st.address_byte_select_s1 = address_byte_select;
    next_st.address_byte_select_s2 = st.address_byte_select_s1;
    next_st.address_byte_select_q = st.address_byte_select_s2;
    next_st.strb_s1 = program_strobe_n;
    next_st.strb_s2 = st.strb_s1;
    next_st.strb_q = st.strb_s2;
    next_st.vpp_s1 = vpp_applied;
    next_st.vpp_s2 = st.vpp_s1;
    next_st.p3_s1 = port3_in;
    next_st.p3_s2 = st.p3_s1;
    next_st.p1_s1 = port1_in;
    next_st.p1_s2 = st.p1_s1;
    next_st.in_sess = in_session;
    // port 1 drives only outside programming; no oe for unused code
    next_st.p1_oe = in_session & ~st.vpp_s2 & (st.mode != M_SEC2); // [R10] [R12]

    if (st.rpin_s2 && st.fsm != S_SHIFT && (osc_rise || !in_session)) begin
      // a high pin ends the session at osc rise; code bits pass in shift [R5]
      if (st.fsm != S_ARMED) begin
        next_st.fsm = S_IDLE;
      end
      next_st.bitcnt = '0;
      next_st.data_valid = 1'b0;
      next_st.p1_oe = 1'b0;
      next_st.pulses = '0;
      next_st.prog_done = 1'b0;
      if (osc_rise && st.hold_cnt != RESET_HOLD_CLKS) begin
        next_st.hold_cnt = st.hold_cnt + CNT_ONE;
        if (st.hold_cnt + CNT_ONE == RESET_HOLD_CLKS) begin
          next_st.fsm = S_ARMED; // [R3]
        end
      end
    end else begin
      next_st.hold_cnt = '0;
      case (st.fsm)
        S_ARMED: begin
          // first low sample is bit 0; all defined codes start with 0
          if (osc_rise) begin
            next_st.code = shifted; // [R2]
            next_st.bitcnt = 4'h1;
            next_st.fsm = S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (osc_rise) begin
            next_st.code = shifted; // [R1] [R2]
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == CODE_LAST_BIT) begin
              next_st.fsm = S_SESSION;
              next_st.vcnt = '0;
              next_st.lo_cnt = '0;
              case (shifted)
                CODE_USER: next_st.mode = M_USER; // [R19]
                CODE_KEY: next_st.mode = M_KEY; // [R19]
                CODE_SEC1: next_st.mode = M_SEC1; // [R20] [R21]
                CODE_SEC2: next_st.mode = M_SEC2; // [R20]
                default: next_st.fsm = S_NONE; // [R22]
              endcase
            end
          end
        end
        S_SESSION: begin
          // upper bits: select must stay high long enough
          if (st.address_byte_select_s2) begin
            next_st.lo_cnt = '0;
            if (osc_rise && st.address_byte_select_cnt != ADDRESS_BYTE_SELECT_MIN_CLKS) begin
              next_st.address_byte_select_cnt = st.address_byte_select_cnt + CNT_ONE;
            end
          end else if (address_byte_select_fall) begin
            if (st.address_byte_select_cnt == ADDRESS_BYTE_SELECT_MIN_CLKS) begin
              next_st.addr_hi = st.p3_s2[HI_BITS-1:0]; // [R6] [R9]
            end
            next_st.address_byte_select_cnt = '0;
          end else if (st.p3_s2 != st.p3_last) begin
            next_st.p3_last = st.p3_s2;
            next_st.lo_cnt = '0;
          end else if (osc_rise && st.lo_cnt != LOW_STABLE_CLKS) begin
            next_st.lo_cnt = st.lo_cnt + CNT_ONE;
            if (st.lo_cnt + CNT_ONE == LOW_STABLE_CLKS) begin
              next_st.addr_lo = st.p3_last; // [R8]
              // new address restarts the verify delay
              next_st.vcnt = '0;
              next_st.data_valid = 1'b0;
            end
          end
          if (prog_on) begin
            next_st.vcnt = '0;
            next_st.data_valid = 1'b0;
            if (strb_rise && st.pulses != PULSE_LAST) begin
              next_st.pulses = st.pulses + 6'h01;
              if (st.pulses + 6'h01 == PULSE_LAST && !st.prog_done) begin
                next_st.prog_done = 1'b1; // [R11] [R23]
                case (st.mode)
                  M_USER: begin
                    if (!st.sec1) begin
                      // cells only go from one to zero
                      next_st.mem[addr] = mem_byte & st.p1_s2; // [R15]
                    end
                  end
                  M_KEY: begin
                    if (!st.sec1) begin
                      next_st.key[key_idx] = key_byte & st.p1_s2; // [R15]
                    end
                  end
                  M_SEC1: next_st.sec1 = 1'b1; // [R17] [R20]
                  default: next_st.sec2 = 1'b1; // [R17] [R20]
                endcase
              end
            end
          end else begin
            next_st.pulses = '0;
            next_st.prog_done = 1'b0;
            if (verify_on) begin
              if (osc_rise && st.vcnt != VERIFY_CLKS) begin
                next_st.vcnt = st.vcnt + CNT_ONE;
                if (st.vcnt + CNT_ONE == VERIFY_CLKS) begin
                  next_st.data_valid = 1'b1; // [R12]
                end
              end
              if (st.data_valid) begin
                next_st.p1_out = vdata; // [R13] [R16] [R18]
              end
            end
          end
        end
        default: begin
          // idle or unknown code: nothing moves until reset pin rises
          next_st.hold_cnt = '0;
        end
      endcase
    end
  end

  // arrays power up erased
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.key <= {KEY_DEPTH{ERASED_BYTE}};
      st.mem <= {MEM_DEPTH{ERASED_BYTE}};
    end else begin
      st <= next_st;
    end
  end

  assign port1_out = st.p1_out;
  assign port1_oe = st.p1_oe;
  assign session_active = st.in_sess;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_verify_entry;
    in_session && !st.vpp_s2 && $past(st.vpp_s2);
  endsequence
  sequence s_write_pulse;
    prog_on && strb_rise && (st.pulses + 6'h01 == PULSE_LAST) && !st.prog_done;
  endsequence
  a_code_select: assert property ( // [R19]
    in_session |-> ((st.mode == M_USER) == (st.code == CODE_USER)) &&
      ((st.mode == M_KEY) == (st.code == CODE_KEY)))
    else $error("session mode does not match mode code");
  a_bad_code_out: assert property ( // [R22]
    st.fsm == S_NONE |-> !port1_oe && $stable(st.mem) && $stable(st.key))
    else $error("unknown code touched port or arrays");
  a_code_enter: assert property ( // [R1]
    $rose(in_session) |-> $past(osc_rise) && $past(st.bitcnt) == CODE_LAST_BIT)
    else $error("session entered off a tenth bit sample");
  a_verify_wait: assert property ( // [R12]
    s_verify_entry |-> !st.data_valid [*8])
    else $error("verify data valid too early");
  a_verify_count: assert property ( // [R12]
    $rose(st.data_valid) |-> st.vcnt == VERIFY_CLKS && verify_on)
    else $error("verify data valid without full delay");
  a_prog_input: assert property ( // [R10]
    prog_on |=> !port1_oe)
    else $error("port 1 driven under programming voltage");
  a_xnor_data: assert property ( // [R13]
    verify_on && st.data_valid && st.mode == M_USER && !st.sec2 |=>
      port1_out == ~($past(mem_byte) ^ $past(key_byte)))
    else $error("user verify data not xnor of key");
  a_sec1_lock: assert property ( // [R15]
    st.sec1 && (st.mode == M_USER || st.mode == M_KEY) |=>
      $stable(st.mem) && $stable(st.key))
    else $error("array written with security bit 1 set");
  a_sec2_block: assert property ( // [R16]
    verify_on && st.data_valid && st.sec2 && st.mode != M_SEC1 |=>
      port1_out == BLOCKED_BYTE)
    else $error("array verify not blocked by security bit 2");
  a_sec_bits_out: assert property ( // [R18]
    verify_on && st.data_valid && st.mode == M_SEC1 |=>
      port1_out[SEC1_BIT] == $past(st.sec1) &&
      port1_out[SEC2_BIT] == $past(st.sec2))
    else $error("security bit levels misplaced");
  a_addr_hi_latch: assert property ( // [R6]
    $changed(st.addr_hi) |-> $past(address_byte_select_fall) &&
      $past(st.address_byte_select_cnt) == ADDRESS_BYTE_SELECT_MIN_CLKS)
    else $error("upper address latched without long select");
  a_addr_lo_stable: assert property ( // [R8]
    $changed(st.addr_lo) |-> st.lo_cnt == LOW_STABLE_CLKS && !st.address_byte_select_s2)
    else $error("low address taken before stable");
  a_pulse_write: assert property ( // [R11]
    s_write_pulse |=> st.prog_done && st.pulses == PULSE_LAST)
    else $error("write not at final strobe pulse");
  a_sec_prog: assert property ( // [R17]
    $rose(st.sec2) |-> $past(prog_on) && $past(st.mode) == M_SEC2)
    else $error("security bit 2 set outside its mode");
endmodule
`default_nettype wire

/* rtl/epv_pkg.sv */
// constants and types for the program and verify port
package epv_pkg;

  // serial mode code
  localparam int CODE_BITS = 10;
  localparam logic [CODE_BITS-1:0] CODE_USER = 10'h296;
  localparam logic [CODE_BITS-1:0] CODE_KEY = 10'h292;
  localparam logic [CODE_BITS-1:0] CODE_SEC1 = 10'h29A;
  localparam logic [CODE_BITS-1:0] CODE_SEC2 = 10'h298;
  localparam int BITCNT_W = 4;
  localparam logic [BITCNT_W-1:0] CODE_LAST_BIT = 4'h9;

  // address and arrays
  localparam int ADDR_BITS = 11;
  localparam int HI_BITS = 3;
  localparam int KEY_BITS = 4;
  localparam int KEY_DEPTH = 16;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] BLOCKED_BYTE = 8'h00;

  // security bit positions on the data port
  localparam int SEC1_BIT = 7;
  localparam int SEC2_BIT = 6;

  // timing in oscillator clocks
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] RESET_HOLD_CLKS = 6'h18;
  localparam logic [CNT_W-1:0] ADDRESS_BYTE_SELECT_MIN_CLKS = 6'h0D;
  localparam logic [CNT_W-1:0] LOW_STABLE_CLKS = 6'h0D;
  localparam logic [CNT_W-1:0] VERIFY_CLKS = 6'h30;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

  // session sequencing
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ARMED = 3'b001,
    S_SHIFT = 3'b010,
    S_SESSION = 3'b011,
    S_NONE = 3'b100
  } epv_state_e;

  // selected target of a session
  typedef enum logic [1:0] {
    M_USER = 2'b00,
    M_KEY = 2'b01,
    M_SEC1 = 2'b10,
    M_SEC2 = 2'b11
  } epv_mode_e;

endpackage

/* dv/epv_prog_model.sv */
// programmer model for the program and verify pins
`timescale 1ns/1ps
`default_nettype none
module epv_prog_model #(
  parameter int OSC_HALF = 9
) (
  // system clock
  input wire logic clk_sys,
  // programmer pins
  output logic oscillator_input,
  output logic reset_pin,
  output logic address_byte_select,
  output logic [7:0] port3_in,
  output logic program_strobe_n,
  output logic vpp_applied,
  // data port drive
  output logic [7:0] p1_drv,
  output logic p1_en
);
  int div;
  logic [7:0] prog_byte;

  // data port driven exactly while the programming voltage is applied
  assign p1_en = vpp_applied;
  assign p1_drv = vpp_applied ? prog_byte : 8'h00;

  initial begin
    div = 0;
    oscillator_input = 1'b0;
    reset_pin = 1'b1;
    address_byte_select = 1'b0;
    port3_in = 8'h00;
    program_strobe_n = 1'b1;
    vpp_applied = 1'b0;
    prog_byte = 8'h00;
  end

  // free running, edges land just after a system edge
  always @(posedge clk_sys) begin
    div <= (div == OSC_HALF - 1) ? 0 : div + 1;
    if (div == OSC_HALF - 1) begin
      oscillator_input <= #1 ~oscillator_input;
    end
  end

  // pins only move while the oscillator is low
  task automatic cyc(input int n);
    repeat (n) @(negedge oscillator_input);
  endtask

  task automatic send_code(input logic [9:0] code);
    reset_pin = 1'b1;
    program_strobe_n = 1'b1;
    vpp_applied = 1'b0;
    cyc(26);
    for (int i = 0; i < 10; i++) begin
      reset_pin = code[i];
      cyc(1);
    end
    reset_pin = 1'b0;
  endtask

  task automatic end_session();
    reset_pin = 1'b1;
    cyc(2);
  endtask

  // upper bits always reloaded; cheaper than tracking them
  task automatic set_addr(input logic [10:0] a);
    address_byte_select = 1'b1;
    port3_in = {5'h00, a[10:8]};
    cyc(14);
    address_byte_select = 1'b0;
    cyc(3);
    port3_in = a[7:0];
    cyc(14);
  endtask

  task automatic vpp_on(input logic [7:0] d);
    prog_byte = d;
    vpp_applied = 1'b1;
    cyc(4);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      program_strobe_n = 1'b0;
      cyc(1);
      program_strobe_n = 1'b1;
      cyc(1);
    end
  endtask

  task automatic vpp_off();
    vpp_applied = 1'b0;
  endtask
endmodule
`default_nettype wire

/* dv/epv_port_test.sv */
// self-checking bench for the program and verify port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  fails++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module epv_port_test;
  import epv_pkg::*;
  localparam int PULSES = 25;
  typedef struct packed {
    logic [9:0] code;
    logic [10:0] addr;
    logic prog;
    logic [7:0] din;
    logic oe;
    logic [7:0] dout;
  } epv_row_s;
  logic clk_sys;
  logic rst_b;
  wire logic osc, rpin, sel_hi, strobe_n, vpp, p1_en;
  wire logic [7:0] port3_in, p1_drv, port1_in, port1_out;
  wire logic port1_oe, session_active;
  int fails = 0;
  int cmp_count = 0;
  // state carries over from row to row: order matters
  epv_row_s rows [11] = '{
    '{10'h296, 11'h005, 1'b1, 8'hA5, 1'b1, 8'hA5},
    '{10'h292, 11'h005, 1'b1, 8'h0F, 1'b1, 8'h0F},
    '{10'h296, 11'h005, 1'b0, 8'h00, 1'b1, 8'h55},
    '{10'h296, 11'h715, 1'b0, 8'h00, 1'b1, 8'h0F},
    '{10'h29A, 11'h000, 1'b0, 8'h00, 1'b1, 8'h00},
    '{10'h29A, 11'h000, 1'b1, 8'h00, 1'b1, 8'h80},
    '{10'h296, 11'h006, 1'b1, 8'h00, 1'b1, 8'hFF},
    '{10'h292, 11'h005, 1'b0, 8'h00, 1'b1, 8'h00},
    '{10'h298, 11'h000, 1'b1, 8'h00, 1'b0, 8'h00},
    '{10'h29A, 11'h000, 1'b0, 8'h00, 1'b1, 8'hC0},
    '{10'h296, 11'h005, 1'b0, 8'h00, 1'b1, 8'h00}
  };

  // released port shows the inverse, never a stale copy
  assign port1_in = p1_en ? p1_drv : (port1_oe ? port1_out : ~p1_drv);

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  epv_port #(.MEM_DEPTH(2048), .PULSE_COUNT(PULSES)) u_epv_port (
    .clk_sys(clk_sys), .rst_b(rst_b), .oscillator_input(osc),
    .reset_pin(rpin), .address_byte_select(sel_hi), .port3_in(port3_in),
    .program_strobe_n(strobe_n), .vpp_applied(vpp), .port1_in(port1_in),
    .port1_out(port1_out), .port1_oe(port1_oe),
    .session_active(session_active)
  );

  epv_prog_model u_epv_prog_model (
    .clk_sys(clk_sys), .oscillator_input(osc), .reset_pin(rpin),
    .address_byte_select(sel_hi), .port3_in(port3_in),
    .program_strobe_n(strobe_n), .vpp_applied(vpp), .p1_drv(p1_drv),
    .p1_en(p1_en)
  );

  task automatic summarize();
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic session(input epv_row_s r, input int n);
    u_epv_prog_model.send_code(r.code);
    u_epv_prog_model.cyc(2);
    `CHK("session_active", 1'b1, session_active)
    if (r.code == CODE_USER || r.code == CODE_KEY) begin
      u_epv_prog_model.set_addr(r.addr);
    end else begin
      // untouched port 3 still latches once; let that settle first
      u_epv_prog_model.cyc(14);
    end
    if (r.prog) begin
      u_epv_prog_model.vpp_on(r.din);
      `CHK("oe_program", 1'b0, port1_oe)
      u_epv_prog_model.pulses(n);
      u_epv_prog_model.vpp_off();
    end
    u_epv_prog_model.cyc(52);
    `CHK("oe_verify", r.oe, port1_oe)
    if (r.oe) `CHK("verify_data", r.dout, port1_out)
    u_epv_prog_model.end_session();
  endtask

  initial begin
    rst_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    foreach (rows[i]) begin
      session(rows[i], PULSES);
    end
    // reset lands in a live verify session
    u_epv_prog_model.send_code(CODE_USER);
    u_epv_prog_model.set_addr(11'h005);
    u_epv_prog_model.cyc(52);
    `CHK("oe_live", 1'b1, port1_oe)
    @(posedge clk_sys);
    #1 rst_b = 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK("oe_reset", 1'b0, port1_oe)
    `CHK("out_reset", 8'h00, port1_out)
    `CHK("session_reset", 1'b0, session_active)
    rst_b = 1'b1;
    u_epv_prog_model.end_session();
    // one pulse short leaves the erased cell alone
    session('{CODE_USER, 11'h001, 1'b1, 8'h00, 1'b1, 8'hFF}, PULSES - 1);
    // undefined code gives no session
    u_epv_prog_model.send_code(10'h2F0);
    u_epv_prog_model.cyc(52);
    `CHK("session_bad", 1'b0, session_active)
    `CHK("oe_bad", 1'b0, port1_oe)
    u_epv_prog_model.end_session();
    summarize();
  end

  // about two and a half times the expected run length
  initial begin
    #900000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
